// >>> inc/mpwm_pkg.sv
// Shared constants for the motor pulse-width modulator time base
package mpwm_pkg;
  localparam int          DW         = 12;      // Period and duty width
  localparam int          NGEN       = 4;       // Duty generators
  localparam int          NPAIR      = 3;       // Output pairs
  localparam int          NOUT       = 7;       // Output pins
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_PERIOD = 8'h04;
  localparam logic [7:0]  OFS_DUTY0  = 8'h08;   // Duty n at 8'h08 + 4*n
  localparam logic [7:0]  OFS_DEAD   = 8'h18;
  localparam logic [7:0]  OFS_OUTCFG = 8'h1c;
  localparam logic [7:0]  OFS_STAT   = 8'h20;
  // Control register bit positions
  localparam int          C_RUN      = 0;
  localparam int          C_LOAD     = 1;
  localparam int          C_CENTER   = 2;
  localparam int          C_ITYPE    = 3;
  localparam int          C_MODE     = 4;       // Two bits
  localparam int          C_GROUP    = 6;
  localparam int          C_PIE      = 7;
  localparam int          C_BIE      = 8;
  localparam int          C_PSC      = 9;       // Three bits
  localparam int          CTRL_W     = 12;
  // Output config: polarity in low six bits, enables above
  localparam int          O_POL      = 0;
  localparam int          O_OE       = 8;
  // Status bit positions
  localparam int          S_PPEND    = 0;
  localparam int          S_BPEND    = 1;
  localparam int          S_RUN      = 2;
  localparam int          S_DOWN     = 3;
  localparam int          S_CNT      = 16;
  // Pairing modes
  localparam logic [1:0]  MODE_IND   = 2'b00;
  localparam logic [1:0]  MODE_COMP  = 2'b01;
  localparam logic [1:0]  MODE_SYNC  = 2'b10;
  localparam logic [1:0]  MODE_GRP   = 2'b11;
  localparam logic [11:0] DUTY_ZERO  = 12'h000;
  localparam logic [11:0] DUTY_FULL  = 12'hfff;
  localparam logic [11:0] PERIOD_RST = 12'hfff;
  localparam logic [7:0]  DEAD_RST   = 8'h00;
endpackage

// >>> rtl/mpwm_top.sv
// Motor pulse-width modulator time base with Wishbone register slave
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
module mpwm_top (
  input  wire logic        clk_i,      // 200 MHz CPU clock
  input  wire logic        rst_i,      // Synchronous reset, high
  input  wire logic        wb_cyc_i,   // Wishbone cycle
  input  wire logic        wb_stb_i,   // Wishbone strobe
  input  wire logic        wb_we_i,    // Write enable
  input  wire logic [7:0]  wb_adr_i,   // Byte address
  input  wire logic [3:0]  wb_sel_i,   // Byte selects
  input  wire logic [31:0] wb_dat_i,   // Write data
  output logic      [31:0] wb_dat_o,   // Read data
  output logic             wb_ack_o,   // Acknowledge
  input  wire logic        icp_mode_i, // In-circuit programming pin
  input  wire logic        brake_i,    // External brake pin, high
  output logic      [6:0]  pwm_out_o,  // Channel pin levels
  output logic      [6:0]  pwm_oe_o,   // Channel pin drive enables
  output logic             period_irq_o, // Periodic interrupt request
  output logic             brake_irq_o   // Brake interrupt request
);
  // Register file
  logic [mpwm_pkg::CTRL_W-1:0] ctrl_reg;        // Control bits
  logic [11:0]                 period_hold_reg; // First period buffer
  logic [11:0]                 period_act_reg;  // Active reload value
  logic [11:0]                 duty_hold_reg [mpwm_pkg::NGEN]; // First duty buffers
  logic [11:0]                 duty_act_reg  [mpwm_pkg::NGEN]; // Active compares
  logic [7:0]                  dead_reg;        // Dead-time count
  logic [15:0]                 outcfg_reg;      // Polarity and enables
  logic                        ppend_reg;       // Periodic pending
  logic                        bpend_reg;       // Brake pending
  // Time base
  logic [11:0] cnt_reg;       // Modulator counter
  logic        down_reg;      // Counting down
  logic        run_d_reg;     // Run bit one cycle ago
  logic        center_reg;    // Alignment in use
  logic [7:0]  pre_reg;       // Prescaler counter
  logic [1:0]  icp_sync_reg;  // Programming pin synchroniser
  logic [1:0]  brk_sync_reg;  // Brake pin synchroniser
  logic        brk_d_reg;     // Synchronised brake delayed
  localparam int NG = mpwm_pkg::NGEN;
  logic [NG-1:0] gen_reg;     // Generator outputs

  // Decoded controls
  logic        run;           // Run bit
  logic        active;        // Running and not in programming mode
  logic        tick;          // Prescaled counter clock
  logic [7:0]  pre_mask;      // Prescaler terminal mask
  logic        match;         // Period match on this tick
  logic        under;         // Centre underflow on this tick
  logic        load_evt;      // Double-buffer transfer now
  logic        irq_evt;       // Periodic request now
  logic [1:0]  mode;          // Pairing mode
  logic        group_follow_bit;           // Group follow
  logic        wr;            // Bus write this cycle
  logic        rd_hit;        // Bus access taken
  logic        clr_p;         // Software clears periodic flag
  logic        clr_b;         // Software clears brake flag

  assign run      = ctrl_reg[mpwm_pkg::C_RUN];
  assign active   = run && !icp_sync_reg[1];
  assign pre_mask = ~(8'hff << ctrl_reg[mpwm_pkg::C_PSC +: 3]);
  assign tick     = active && ((pre_reg & pre_mask) == pre_mask);
  assign match    = tick && !down_reg && (cnt_reg == period_act_reg);
  assign under    = tick && center_reg && down_reg && (cnt_reg == 12'h000);
  // Edge mode loads at period match, centre mode at underflow
  assign load_evt = ctrl_reg[mpwm_pkg::C_LOAD] && (center_reg ? under : match);
  assign irq_evt  = center_reg ? (ctrl_reg[mpwm_pkg::C_ITYPE] ? match : under) : match;
  assign mode     = ctrl_reg[mpwm_pkg::C_MODE +: 2];
  assign group_follow_bit      = ctrl_reg[mpwm_pkg::C_GROUP] || (mode == mpwm_pkg::MODE_GRP);
  assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign clr_p    = wr && wb_sel_i[0] && (wb_adr_i == mpwm_pkg::OFS_STAT) && wb_dat_i[mpwm_pkg::S_PPEND];
  assign clr_b    = wr && wb_sel_i[0] && (wb_adr_i == mpwm_pkg::OFS_STAT) && wb_dat_i[mpwm_pkg::S_BPEND];

  // Merge a 12-bit value from low byte and high byte nibble
  function automatic logic [11:0] merge12(input logic [11:0] old, input logic [3:0] sel, input logic [31:0] d);
    logic [11:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = d[7:0];
    end
    if (sel[1]) begin
      v[11:8] = d[11:8];
    end
    return v;
  endfunction

  // Input synchronisers for the two pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icp_sync_reg <= 2'b00;
      brk_sync_reg <= 2'b00;
      brk_d_reg    <= 1'b0;
    end else begin
      icp_sync_reg <= {icp_sync_reg[0], icp_mode_i};
      brk_sync_reg <= {brk_sync_reg[0], brake_i};
      brk_d_reg    <= brk_sync_reg[1];
    end
  end

  // Control register; hardware clears load after a transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= '0;
    end else begin
      if (load_evt) begin
        ctrl_reg[mpwm_pkg::C_LOAD] <= 1'b0;
      end
      if (wr && (wb_adr_i == mpwm_pkg::OFS_CTRL)) begin
        // Software write wins over the hardware clear of load
        if (wb_sel_i[0]) begin
          ctrl_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ctrl_reg[11:8] <= wb_dat_i[11:8];
        end
      end
    end
  end

  // First buffers: software writes only these
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_hold_reg <= mpwm_pkg::PERIOD_RST;
      dead_reg        <= mpwm_pkg::DEAD_RST;
      outcfg_reg      <= '0;
    end else if (wr) begin
      if (wb_adr_i == mpwm_pkg::OFS_PERIOD) begin
        period_hold_reg <= merge12(period_hold_reg, wb_sel_i, wb_dat_i);
      end
      if ((wb_adr_i == mpwm_pkg::OFS_DEAD) && wb_sel_i[0]) begin
        dead_reg <= wb_dat_i[7:0];
      end
      if (wb_adr_i == mpwm_pkg::OFS_OUTCFG) begin
        if (wb_sel_i[0]) begin
          outcfg_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          outcfg_reg[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Active period: run rise or load event copies the holding value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_act_reg <= mpwm_pkg::PERIOD_RST;
      run_d_reg      <= 1'b0;
    end else begin
      run_d_reg <= run;
      if ((run && !run_d_reg) || load_evt) begin
        period_act_reg <= period_hold_reg;
      end
    end
  end

  // Alignment latched only while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      center_reg <= 1'b0;
    end else if (!run) begin
      center_reg <= ctrl_reg[mpwm_pkg::C_CENTER];
    end
  end

  // Prescaler counter
  always_ff @(posedge clk_i) begin
    if (rst_i || !active) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  // Up or up/down counter
  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      cnt_reg  <= 12'h000;
      down_reg <= 1'b0;
    end else if (tick) begin
      if (!center_reg) begin
        // Edge mode restarts from zero after the period match
        cnt_reg <= match ? 12'h000 : cnt_reg + 12'h001;
      end else if (!down_reg) begin
        // Centre mode turns round at the period match
        if (match) begin
          down_reg <= (period_act_reg != 12'h000);
          cnt_reg  <= (period_act_reg != 12'h000) ? cnt_reg - 12'h001 : 12'h000;
        end else begin
          cnt_reg <= cnt_reg + 12'h001;
        end
      end else if (under) begin
        down_reg <= 1'b0;
        cnt_reg  <= 12'h001;
      end else begin
        cnt_reg <= cnt_reg - 12'h001;
      end
    end
  end

  // Duty buffers and generators, one per duty channel
  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : gen_duty
      logic [7:0]  dofs;
      logic [11:0] duty_use;
      assign dofs     = mpwm_pkg::OFS_DUTY0 + 8'(4 * g);
      // Grouped channels one and two take the channel zero compare
      assign duty_use = (group_follow_bit && (g == 1 || g == 2)) ? duty_act_reg[0] : duty_act_reg[g];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          duty_hold_reg[g] <= mpwm_pkg::DUTY_ZERO;
        end else if (wr && (wb_adr_i == dofs)) begin
          duty_hold_reg[g] <= merge12(duty_hold_reg[g], wb_sel_i, wb_dat_i);
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          duty_act_reg[g] <= mpwm_pkg::DUTY_ZERO;
        end else if (load_evt || (run && !run_d_reg)) begin
          duty_act_reg[g] <= duty_hold_reg[g];
        end
      end
      // High below the compare: low at duty match, high again once the count is back below it
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          gen_reg[g] <= 1'b0;
        end else if (active) begin
          gen_reg[g] <= (duty_use == mpwm_pkg::DUTY_FULL) || (cnt_reg < duty_use);
        end
      end
    end
  endgenerate

  // Pair logic with dead-time insertion
  logic [5:0] raw; // Six paired channels before polarity
  generate
    for (g = 0; g < mpwm_pkg::NPAIR; g++) begin : gen_pair
      logic       src;
      logic       src_d_reg;
      logic [7:0] dt_reg;
      logic       dt_busy_reg;
      logic       comp;
      assign src  = gen_reg[g];
      assign comp = (mode == mpwm_pkg::MODE_COMP) || (mode == mpwm_pkg::MODE_GRP);
      // In complementary and group modes a change of the generator blanks both pins for count plus one cycles
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          src_d_reg   <= 1'b0;
          dt_reg      <= 8'h00;
          dt_busy_reg <= 1'b0;
        end else begin
          src_d_reg <= src;
          if (src != src_d_reg) begin
            dt_reg      <= dead_reg;
            dt_busy_reg <= 1'b1;
          end else if (dt_reg != 8'h00) begin
            dt_reg <= dt_reg - 8'h01;
          end else begin
            dt_busy_reg <= 1'b0;
          end
        end
      end
      always_comb begin
        if (comp) begin
          raw[2*g]   = src_d_reg && !dt_busy_reg;
          raw[2*g+1] = !src_d_reg && !dt_busy_reg;
        end else if (mode == mpwm_pkg::MODE_SYNC) begin
          raw[2*g]   = src_d_reg;
          raw[2*g+1] = src_d_reg;
        end else begin
          raw[2*g]   = src_d_reg;
          raw[2*g+1] = 1'b0;
        end
      end
    end
  endgenerate

  // Pins: polarity applied to pins zero to five; programming mode releases every pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_out_o <= '0;
      pwm_oe_o  <= '0;
    end else begin
      pwm_out_o[5:0] <= raw ^ outcfg_reg[mpwm_pkg::O_POL +: 6];
      pwm_out_o[6]   <= gen_reg[3];
      pwm_oe_o       <= icp_sync_reg[1] ? 7'h00 : outcfg_reg[mpwm_pkg::O_OE +: 7];
    end
  end

  // Pending flags; a new event beats a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ppend_reg <= 1'b0;
      bpend_reg <= 1'b0;
    end else begin
      if (irq_evt) begin
        ppend_reg <= 1'b1;
      end else if (clr_p) begin
        ppend_reg <= 1'b0;
      end
      if (brk_sync_reg[1] && !brk_d_reg) begin
        bpend_reg <= 1'b1;
      end else if (clr_b) begin
        bpend_reg <= 1'b0;
      end
    end
  end

  // Interrupt request outputs gated by their enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_irq_o <= 1'b0;
      brake_irq_o  <= 1'b0;
    end else begin
      period_irq_o <= ppend_reg && ctrl_reg[mpwm_pkg::C_PIE];
      brake_irq_o  <= bpend_reg && ctrl_reg[mpwm_pkg::C_BIE];
    end
  end

  // Bus answer: one wait state, zero for unmapped reads
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      mpwm_pkg::OFS_CTRL:   rdata[11:0] = ctrl_reg;
      mpwm_pkg::OFS_PERIOD: rdata[11:0] = period_hold_reg;
      mpwm_pkg::OFS_DEAD:   rdata[7:0]  = dead_reg;
      mpwm_pkg::OFS_OUTCFG: rdata[15:0] = outcfg_reg;
      mpwm_pkg::OFS_STAT: begin
        rdata[mpwm_pkg::S_PPEND]    = ppend_reg;
        rdata[mpwm_pkg::S_BPEND]    = bpend_reg;
        rdata[mpwm_pkg::S_RUN]      = active;
        rdata[mpwm_pkg::S_DOWN]     = down_reg;
        rdata[mpwm_pkg::S_CNT +: 12] = cnt_reg;
      end
      default: begin
        for (int i = 0; i < NG; i++) begin
          if (wb_adr_i == mpwm_pkg::OFS_DUTY0 + 8'(4 * i)) begin
            rdata[11:0] = duty_hold_reg[i];
          end
        end
      end
    endcase
  end

  // Acknowledge and read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= rd_hit;
      wb_dat_o <= rd_hit ? rdata : 32'h0000_0000;
    end
  end
endmodule

// >>> tb/mpwm_properties.sv
// Port-level checks for the modulator time base
`timescale 1ns/10ps
module mpwm_properties (
  input  wire logic        clk_i,        // Module clock
  input  wire logic        rst_i,        // Synchronous reset
  input  wire logic        wb_cyc_i,     // Bus cycle
  input  wire logic        wb_stb_i,     // Bus strobe
  input  wire logic        wb_we_i,      // Bus write
  input  wire logic [7:0]  wb_adr_i,     // Bus address
  input  wire logic [31:0] wb_dat_o,     // Read data
  input  wire logic        wb_ack_o,     // Acknowledge
  input  wire logic        icp_mode_i,   // Programming mode pin
  input  wire logic [6:0]  pwm_out_o,    // Pin levels
  input  wire logic [6:0]  pwm_oe_o,     // Pin enables
  input  wire logic        period_irq_o, // Periodic request
  input  wire logic        brake_irq_o   // Brake request
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Any write beat, the only thing that may clear a request
  wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i;
  // A request newly taken by the slave
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // A one-cycle answer
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_one_cycle_a: assert property (s_take |=> s_answer) else $error("ack is not a one-cycle answer");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  unmapped_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h20) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_tristate_a: assert property ($fell(rst_i) |-> pwm_oe_o == 7'h0 && pwm_out_o == 7'h0)
    else $error("pins driven after reset");
  icp_tristate_a: assert property (icp_mode_i [*5] |-> pwm_oe_o == 7'h0)
    else $error("pins driven in programming mode");
  brake_sticky_a: assert property (brake_irq_o && !bus_wr |=> brake_irq_o)
    else $error("brake request dropped alone");
  period_sticky_a: assert property (period_irq_o && !bus_wr |=> period_irq_o)
    else $error("periodic request dropped alone");
endmodule

// >>> tb/mpwm_gate_model.sv
// Gate driver inputs behind the modulator pins
`timescale 1ns/10ps
module mpwm_gate_model (
  input  wire logic [6:0] pin_i,   // Pin levels from the modulator
  input  wire logic [6:0] oe_i,    // Pin drive enables
  input  wire logic       fault_i, // Bench request for a fault
  output logic      [6:0] gate_o,  // Levels seen by the drivers
  output logic            brake_o  // Fault line back to the modulator
);
  // Undriven pins fall to the drivers' pull-downs, never hold a level
  always_comb begin
    for (int i = 0; i < 7; i++) gate_o[i] = oe_i[i] ? pin_i[i] : 1'b0;
    brake_o = fault_i;
  end
endmodule

// >>> tb/mpwm_top_bench.sv
// Self-checking bench for the modulator time base
`timescale 1ns/10ps
module mpwm_top_bench;
  localparam int          PER    = 9;  // Period used throughout
  localparam logic [11:0] CORNER [4] = '{12'h000, 12'hfff, 12'h00a, 12'h009};
  logic        clk, rst, cyc, stb, we, in_circuit_programming, fault, brake, ack, pirq, birq; // Bench nets
  logic [7:0]  adr;                    // Bus address
  logic [3:0]  sel;                    // Byte selects
  logic [31:0] dw, dr, r, d;           // Bus data
  logic [6:0]  pout, poe, gate;        // Pin side
  logic [11:0] dv [4];                 // Duties per generator
  logic [11:0] nd;                     // Duty written without load
  logic        seen;                   // Down count observed
  int          n_fail, tests_run, seed, w, psc, ov;
  int          hi [7];                 // High counts per pin
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  mpwm_top u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .icp_mode_i(in_circuit_programming), .brake_i(brake),
    .pwm_out_o(pout), .pwm_oe_o(poe), .period_irq_o(pirq), .brake_irq_o(birq));
  mpwm_gate_model u_gate (.pin_i(pout), .oe_i(poe), .fault_i(fault), .gate_o(gate), .brake_o(brake));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic bus cycle, released at the edge that samples ack
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] v, output logic [31:0] q);
    int t;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dw} <= {2'b11, w_en, a, 4'h3, v};
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (t > 20) begin
        n_fail++;
        tally_and_finish();
      end
    end while (ack !== 1'b1);
    q = dr;
    {cyc, stb} <= 2'b00;
  endtask
  // Wait for a request line, bounded
  task automatic wait_irq(input logic brk);
    int t;
    t = 0;
    while ((brk ? birq : pirq) !== 1'b1) begin
      @(negedge clk);
      t++;
      if (t > 200) begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask
  // Count high cycles per pin and pair-zero overlap over w cycles
  task automatic measure();
    for (int i = 0; i < 7; i++) hi[i] = 0;
    ov = 0;
    repeat (w) begin
      @(negedge clk);
      for (int i = 0; i < 7; i++) if (gate[i] === 1'b1) hi[i]++;
      if (gate[1:0] === 2'b11) ov++;
    end
  endtask
  // Control word with both interrupts enabled, run clear
  function automatic logic [31:0] mk_ctrl(logic ctr, logic [1:0] md, logic group_follow_bit, logic [2:0] p);
    logic [31:0] c;
    c = 32'h0;
    c[mpwm_pkg::C_CENTER] = ctr;
    c[mpwm_pkg::C_MODE +: 2] = md;
    c[mpwm_pkg::C_GROUP] = group_follow_bit;
    c[mpwm_pkg::C_PIE] = 1'b1;
    c[mpwm_pkg::C_BIE] = 1'b1;
    c[mpwm_pkg::C_PSC +: 3] = p;
    return c;
  endfunction
  // Expected high cycles over three edge-aligned periods
  function automatic int exp_high(logic [11:0] v, int p);
    if (v == mpwm_pkg::DUTY_FULL || v > PER) return 3 * (PER + 1) << p;
    return 3 * v << p;
  endfunction
  // Stop, start on a rising run bit, settle, then measure
  task automatic start(input logic [31:0] c);
    wb(1'b1, mpwm_pkg::OFS_CTRL, c, r);
    wb(1'b1, mpwm_pkg::OFS_CTRL, c | 32'h1, r);
    repeat (w) @(posedge clk);
    measure();
  endtask
  // Poll the down-count status bit across more than a cycle
  task automatic poll_down();
    seen = 1'b0;
    repeat (12) begin
      wb(1'b0, mpwm_pkg::OFS_STAT, 32'h0, r);
      seen |= r[mpwm_pkg::S_DOWN];
    end
  endtask
  // Clear the periodic flag, then poll until it sets again; r keeps that status
  task automatic irq_phase();
    wb(1'b1, mpwm_pkg::OFS_STAT, 32'h1, r);
    seen = 1'b0;
    for (int i = 0; i < 12 && !seen; i++) begin
      wb(1'b0, mpwm_pkg::OFS_STAT, 32'h0, r);
      seen = r[mpwm_pkg::S_PPEND];
    end
  endtask
  // Main sequence
  initial begin
    seed = 32'h8d61efe3;
    {n_fail, tests_run} = '0;
    {rst, cyc, stb, we, in_circuit_programming, fault, adr, sel, dw} = {1'b1, 5'h0, 8'h0, 4'h0, 32'h0};
    w = 3 * (PER + 1);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("oe at reset", 32'(poe), 32'h0);
    wb(1'b0, mpwm_pkg::OFS_PERIOD, 32'h0, r);
    chk("period reset", r, {20'h0, mpwm_pkg::PERIOD_RST});
    wb(1'b0, 8'h30, 32'h0, r);
    chk("unmapped read", r, 32'h0);
    repeat (4) begin
      d = $random(seed);
      wb(1'b1, mpwm_pkg::OFS_PERIOD, d, r);
      wb(1'b0, mpwm_pkg::OFS_PERIOD, 32'h0, r);
      chk("period pack", r, {20'h0, d[11:0]});
    end
    wb(1'b1, mpwm_pkg::OFS_PERIOD, PER, r);
    wb(1'b1, mpwm_pkg::OFS_OUTCFG, 32'h7f00, r);
    // Corners on generator zero for four rounds, random duties otherwise, three prescales
    for (int k = 0; k < 8; k++) begin
      psc = k % 3;
      w = 3 * (PER + 1) << psc;
      for (int g = 0; g < 4; g++) begin
        dv[g] = (k < 4 && g == 0) ? CORNER[k] : 12'(($random(seed) & 7) + 1);
        wb(1'b1, 8'(mpwm_pkg::OFS_DUTY0 + 4 * g), {20'h0, dv[g]}, r);
      end
      start(mk_ctrl(1'b0, mpwm_pkg::MODE_IND, 1'b0, 3'(psc)));
      for (int g = 0; g < 4; g++) chk("duty high", hi[2*g], exp_high(dv[g], psc));
      chk("odd idle", hi[1] + hi[3] + hi[5], 0);
    end
    // Held duty waits for the load bit
    w = 3 * (PER + 1);
    start(mk_ctrl(1'b0, mpwm_pkg::MODE_IND, 1'b0, 3'h0));
    nd = (dv[0] == 12'h2) ? 12'h5 : 12'h2;
    wb(1'b1, mpwm_pkg::OFS_DUTY0, {20'h0, nd}, r);
    measure();
    chk("no load", hi[0], exp_high(dv[0], 0));
    wb(1'b1, mpwm_pkg::OFS_CTRL, mk_ctrl(1'b0, mpwm_pkg::MODE_IND, 1'b0, 3'h0) | 32'h3, r);
    repeat (w) @(posedge clk);
    measure();
    chk("load", hi[0], exp_high(nd, 0));
    // Pending flag: cleared while idle, set by running, kept after stop
    wb(1'b1, mpwm_pkg::OFS_CTRL, mk_ctrl(1'b0, mpwm_pkg::MODE_IND, 1'b0, 3'h0), r);
    wb(1'b1, mpwm_pkg::OFS_STAT, 32'h1, r);
    repeat (20) @(negedge clk);
    chk("idle no irq", 32'(pirq), 32'h0);
    start(mk_ctrl(1'b0, mpwm_pkg::MODE_IND, 1'b0, 3'h0));
    wait_irq(1'b0);
    wb(1'b1, mpwm_pkg::OFS_CTRL, mk_ctrl(1'b0, mpwm_pkg::MODE_IND, 1'b0, 3'h0), r);
    repeat (20) @(negedge clk);
    chk("pending kept", 32'(pirq), 32'h1);
    // Centre counting turns down
    start(mk_ctrl(1'b1, mpwm_pkg::MODE_IND, 1'b0, 3'h0));
    poll_down();
    chk("count down", 32'(seen), 32'h1);
    // Timing select: underflow request seen while counting up, match request while down
    irq_phase();
    chk("underflow irq", 32'(seen), 32'h1);
    chk("underflow phase", 32'(r[mpwm_pkg::S_DOWN]), 32'h0);
    wb(1'b1, mpwm_pkg::OFS_CTRL, mk_ctrl(1'b1, mpwm_pkg::MODE_IND, 1'b0, 3'h0) | 32'h1 | (32'h1 << mpwm_pkg::C_ITYPE), r);
    irq_phase();
    chk("match irq", 32'(seen), 32'h1);
    chk("match phase", 32'(r[mpwm_pkg::S_DOWN]), 32'h1);
    // Complementary pair with dead time; centre request ignored while running
    wb(1'b1, mpwm_pkg::OFS_DEAD, 32'h3, r);
    wb(1'b1, mpwm_pkg::OFS_DUTY0, 32'h4, r);
    start(mk_ctrl(1'b0, mpwm_pkg::MODE_COMP, 1'b0, 3'h0));
    chk("no overlap", ov, 0);
    chk("dead band", 32'(hi[0] + hi[1] >= w - 6 * 5 && hi[0] + hi[1] <= w - 6 * 4), 32'h1);
    wb(1'b1, mpwm_pkg::OFS_CTRL, mk_ctrl(1'b1, mpwm_pkg::MODE_COMP, 1'b0, 3'h0) | 32'h1, r);
    poll_down();
    chk("no live align", 32'(seen), 32'h0);
    // Synchronous pairs, inverted pin one, group follow
    wb(1'b1, mpwm_pkg::OFS_OUTCFG, 32'h7f02, r);
    wb(1'b1, 8'(mpwm_pkg::OFS_DUTY0 + 4), 32'h7, r);
    start(mk_ctrl(1'b0, mpwm_pkg::MODE_SYNC, 1'b1, 3'h0));
    chk("sync inverted", hi[1], w - hi[0]);
    chk("group follow", hi[2], exp_high(12'h4, 0));
    chk("group duty", hi[3], exp_high(12'h4, 0));
    // Group mode: pair one complementary with dead time on the channel zero duty
    start(mk_ctrl(1'b0, mpwm_pkg::MODE_GRP, 1'b0, 3'h0));
    chk("group pair", 32'(hi[3] >= 3 && hi[3] <= 6 && hi[2] + hi[3] >= w - 30 && hi[2] + hi[3] <= w - 24), 32'h1);
    // Programming mode drops the drives, exit restores them
    @(posedge clk);
    in_circuit_programming <= 1'b1;
    repeat (8) @(negedge clk);
    chk("icp tristate", 32'(poe), 32'h0);
    @(posedge clk);
    in_circuit_programming <= 1'b0;
    repeat (8) @(negedge clk);
    chk("icp exit", 32'(poe), 32'h7f);
    // Brake request raised, then cleared
    @(posedge clk);
    fault <= 1'b1;
    wait_irq(1'b1);
    @(posedge clk);
    fault <= 1'b0;
    wb(1'b1, mpwm_pkg::OFS_STAT, 32'h2, r);
    repeat (3) @(negedge clk);
    chk("brake clear", 32'(birq), 32'h0);
    tally_and_finish();
  end
endmodule
bind mpwm_top mpwm_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .icp_mode_i(icp_mode_i),
  .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o), .period_irq_o(period_irq_o), .brake_irq_o(brake_irq_o));
